/* File: verilog/gdsr_regs.sv */
`timescale 1ns/1ns
`include "gdsr_cfg.svh"

// Function
// RQ1: primary dead time upper nibble, 16 ns times code plus one.
// RQ2: secondary dead time lower nibble, same 16 ns step encoding.
// RQ3: regulation set-point 8-bit code drives linear reference DAC.
// RQ4: external reference reaches its pin only in master mode 01.
// RQ5: external reference 8-bit code, ground referenced, no pedestal.
// RQ6: primary enable bit gates primary drive, independent of secondary.
// RQ7: secondary enable bit gates secondary drive, independent of primary.
// RQ8: bypass bit set passes turn-on with no added delay.
// RQ9: drive held inactive for the dead time, counted in clock cycles.
module gdsr_regs
  import gdsr_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       primary_turn_on_request,
  input  wire logic       secondary_turn_on_request,
  output logic            primary_gate_drive,
  output logic            secondary_gate_drive,
  output logic      [7:0] regulation_dac_code,
  output logic      [7:0] external_ref_code,
  output logic            external_ref_pin_connect
);

  // ========================================================================
  // register state
  gdsr_byte_t dead_time_q;
  gdsr_byte_t dead_time_d;
  gdsr_byte_t reg_setpt_q;
  gdsr_byte_t reg_setpt_d;
  gdsr_byte_t ext_ref_q;
  gdsr_byte_t ext_ref_d;
  logic [3:0] drive_ctrl_q;
  logic [3:0] drive_ctrl_d;
  logic [1:0] master_slave_select_q;
  logic [1:0] master_slave_select_d;
  gdsr_byte_t rdata_q;
  gdsr_byte_t rdata_d;
  logic       connect_q;
  logic       connect_d;

  logic       primary_drive_enable;
  logic       secondary_drive_enable;
  logic       primary_dead_time_bypass;
  logic       secondary_dead_time_bypass;
  logic [3:0] primary_dead_time_code;
  logic [3:0] secondary_dead_time_code;

  // control fields, kept in the upper nibble layout of the control register
  assign primary_drive_enable       = drive_ctrl_q[3];
  assign secondary_drive_enable     = drive_ctrl_q[2];
  assign primary_dead_time_bypass   = drive_ctrl_q[1];
  assign secondary_dead_time_bypass = drive_ctrl_q[0];
  assign primary_dead_time_code     =
    dead_time_q[`GDSR_PDT_HI:`GDSR_PDT_LO];                        // [RQ1]
  assign secondary_dead_time_code   =
    dead_time_q[`GDSR_SDT_HI:`GDSR_SDT_LO];                        // [RQ2]

  // ========================================================================
  // write decode and read mux; unmapped reads return zero
  always_comb begin
    dead_time_d           = dead_time_q;
    reg_setpt_d           = reg_setpt_q;
    ext_ref_d             = ext_ref_q;
    drive_ctrl_d          = drive_ctrl_q;
    master_slave_select_d = master_slave_select_q;
    rdata_d               = 8'h00;
    if (reg_write) begin
      unique case (reg_addr)
        `GDSR_OFS_DEAD_TIME:  dead_time_d = reg_wdata;
        `GDSR_OFS_REG_SETPT:  reg_setpt_d = reg_wdata;              // [RQ3]
        `GDSR_OFS_EXT_REF:    ext_ref_d   = reg_wdata;              // [RQ5]
        `GDSR_OFS_DRIVE_CTRL: begin
          drive_ctrl_d = {reg_wdata[`GDSR_BIT_PRI_EN],               // [RQ6]
                          reg_wdata[`GDSR_BIT_SEC_EN],               // [RQ7]
                          reg_wdata[`GDSR_BIT_PRI_BY],               // [RQ8]
                          reg_wdata[`GDSR_BIT_SEC_BY]};
        end
        `GDSR_OFS_MODE: begin
          master_slave_select_d = reg_wdata[`GDSR_MSC_HI:`GDSR_MSC_LO];
        end
        default: ;
      endcase
    end
    if (reg_read) begin
      unique case (reg_addr)
        `GDSR_OFS_DEAD_TIME:  rdata_d = dead_time_q;
        `GDSR_OFS_REG_SETPT:  rdata_d = reg_setpt_q;
        `GDSR_OFS_EXT_REF:    rdata_d = ext_ref_q;
        `GDSR_OFS_DRIVE_CTRL: rdata_d = {drive_ctrl_q, 4'h0};
        `GDSR_OFS_MODE:       rdata_d = {6'h00, master_slave_select_q};
        // live drive levels, so software can see the dead timers act
        `GDSR_OFS_STATUS: begin
          rdata_d = {6'h00, primary_gate_drive, secondary_gate_drive};
        end
        default:              rdata_d = 8'h00;
      endcase
    end
    // pin switch follows the mode register; off in stand-alone
    connect_d = (master_slave_select_d == `GDSR_MSC_MASTER);         // [RQ4]
  end

  // register bank
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dead_time_q           <= `GDSR_RST_DEAD_TIME;
      reg_setpt_q           <= `GDSR_RST_REG_SETPT;
      ext_ref_q             <= `GDSR_RST_EXT_REF;
      drive_ctrl_q          <= `GDSR_RST_DRIVE_CTRL;
      master_slave_select_q <= `GDSR_RST_MODE;
      rdata_q               <= 8'h00;
      connect_q             <= 1'b0;
    end else begin
      dead_time_q           <= dead_time_d;
      reg_setpt_q           <= reg_setpt_d;
      ext_ref_q             <= ext_ref_d;
      drive_ctrl_q          <= drive_ctrl_d;
      master_slave_select_q <= master_slave_select_d;
      rdata_q               <= rdata_d;
      connect_q             <= connect_d;
    end
  end

  // dac codes straight from flops; the analog side does the scaling
  assign regulation_dac_code      = reg_setpt_q;                    // [RQ3]
  assign external_ref_code        = ext_ref_q;                      // [RQ5]
  assign external_ref_pin_connect = connect_q;                      // [RQ4]
  assign reg_rdata                = rdata_q;

  // ========================================================================
  // dead timers, one per low-side driver
  gdsr_dead_timer u_primary_timer (
    .ref_clk          (ref_clk),
    .resetn           (resetn),
    .turn_on_request  (primary_turn_on_request),
    .drive_enable     (primary_drive_enable),                       // [RQ6]
    .dead_time_bypass (primary_dead_time_bypass),                   // [RQ8]
    .dead_time_code   (primary_dead_time_code),                     // [RQ1]
    .gate_drive       (primary_gate_drive)                          // [RQ9]
  );

  gdsr_dead_timer u_secondary_timer (
    .ref_clk          (ref_clk),
    .resetn           (resetn),
    .turn_on_request  (secondary_turn_on_request),
    .drive_enable     (secondary_drive_enable),                     // [RQ7]
    .dead_time_bypass (secondary_dead_time_bypass),                 // [RQ8]
    .dead_time_code   (secondary_dead_time_code),                   // [RQ2]
    .gate_drive       (secondary_gate_drive)                        // [RQ9]
  );

  // ========================================================================
  // checks
  chk_pri_dead_max: assert property ( // [RQ1]
    @(posedge ref_clk) disable iff (!resetn)
    ($rose(primary_turn_on_request) && primary_dead_time_code == 4'hF)
    ##0 (primary_turn_on_request && primary_drive_enable
         && !primary_dead_time_bypass)[*7]
    |=> primary_gate_drive && !$past(primary_gate_drive))
    else $error("primary drive not on six cycles after max code");

  chk_sec_dead_min: assert property ( // [RQ2]
    @(posedge ref_clk) disable iff (!resetn)
    ($rose(secondary_turn_on_request) && secondary_dead_time_code == 4'h0)
    ##0 (secondary_turn_on_request && secondary_drive_enable
         && !secondary_dead_time_bypass)[*2]
    |=> secondary_gate_drive && !$past(secondary_gate_drive))
    else $error("secondary drive not on one cycle after min code");

  chk_hold_inactive: assert property ( // [RQ9]
    @(posedge ref_clk) disable iff (!resetn)
    $rose(primary_turn_on_request) && !primary_dead_time_bypass
    |=> !primary_gate_drive)
    else $error("primary drive rose with no dead time");

  chk_setpoint_write: assert property ( // [RQ3]
    @(posedge ref_clk) disable iff (!resetn)
    reg_write && reg_addr == `GDSR_OFS_REG_SETPT
    |=> regulation_dac_code == $past(reg_wdata))
    else $error("regulation set-point not taken from write");

  chk_ext_ref_write: assert property ( // [RQ5]
    @(posedge ref_clk) disable iff (!resetn)
    reg_write && reg_addr == `GDSR_OFS_EXT_REF
    |=> external_ref_code == $past(reg_wdata) ##1 reg_rdata ==
        external_ref_code || !$past(reg_read))
    else $error("external reference code not taken from write");

  chk_pin_master: assert property ( // [RQ4]
    @(posedge ref_clk) disable iff (!resetn)
    reg_write && reg_addr == `GDSR_OFS_MODE
    |=> external_ref_pin_connect ==
        ($past(reg_wdata[1:0]) == `GDSR_MSC_MASTER))
    else $error("external reference pin switch wrong for mode");

  chk_pri_disable: assert property ( // [RQ6]
    @(posedge ref_clk) disable iff (!resetn)
    !primary_drive_enable |=> !primary_gate_drive)
    else $error("primary drive on while disabled");

  chk_sec_disable: assert property ( // [RQ7]
    @(posedge ref_clk) disable iff (!resetn)
    !secondary_drive_enable |=> !secondary_gate_drive)
    else $error("secondary drive on while disabled");

  chk_bypass_pass: assert property ( // [RQ8]
    @(posedge ref_clk) disable iff (!resetn)
    $rose(secondary_turn_on_request) && secondary_drive_enable
    && secondary_dead_time_bypass
    |=> secondary_gate_drive)
    else $error("bypassed secondary drive delayed");

endmodule

/* File: verilog/gdsr_cfg.svh */
`ifndef GDSR_CFG_SVH
`define GDSR_CFG_SVH

// ==========================================================================
// register offsets (byte-wide registers, one per address)
`define GDSR_OFS_DEAD_TIME   8'h00
`define GDSR_OFS_REG_SETPT   8'h01
`define GDSR_OFS_EXT_REF     8'h02
`define GDSR_OFS_DRIVE_CTRL  8'h03
`define GDSR_OFS_MODE        8'h04
`define GDSR_OFS_STATUS      8'h05

// ==========================================================================
// field positions
`define GDSR_PDT_HI          7
`define GDSR_PDT_LO          4
`define GDSR_SDT_HI          3
`define GDSR_SDT_LO          0
`define GDSR_BIT_PRI_EN      7
`define GDSR_BIT_SEC_EN      6
`define GDSR_BIT_PRI_BY      5
`define GDSR_BIT_SEC_BY      4
`define GDSR_MSC_HI          1
`define GDSR_MSC_LO          0
`define GDSR_MSC_MASTER      2'h1

// ==========================================================================
// reset values
`define GDSR_RST_DEAD_TIME   8'h00
`define GDSR_RST_REG_SETPT   8'h00
`define GDSR_RST_EXT_REF     8'h00
`define GDSR_RST_DRIVE_CTRL  4'h0
`define GDSR_RST_MODE        2'h0

// ==========================================================================
// timing: dead time step and clock period, both in ns
`define GDSR_DT_STEP_NS      16
`define GDSR_CLK_PERIOD_NS   50

`endif

/* File: verilog/gdsr_pkg.sv */
`include "gdsr_cfg.svh"

package gdsr_pkg;

  // ========================================================================
  // dead timer states
  typedef enum logic [1:0] {
    GDSR_DT_IDLE,
    GDSR_DT_WAIT,
    GDSR_DT_ON
  } gdsr_dt_state_t;

  typedef logic [7:0] gdsr_byte_t;

  // ========================================================================
  // least dead time in whole cycles, rounded up, never below one
  function automatic logic [3:0] gdsr_dt_cycles(input logic [3:0] code);
    int ns;
    int cyc;
    ns  = `GDSR_DT_STEP_NS * (int'(code) + 1);
    cyc = (ns + `GDSR_CLK_PERIOD_NS - 1) / `GDSR_CLK_PERIOD_NS;
    if (cyc < 1) begin
      cyc = 1;
    end
    return cyc[3:0];
  endfunction

endpackage

/* File: verilog/gdsr_dead_timer.sv */
`timescale 1ns/1ns

// ==========================================================================
// one low-side driver: turn-on delay, bypass and enable gating
module gdsr_dead_timer
  import gdsr_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       turn_on_request,
  input  wire logic       drive_enable,
  input  wire logic       dead_time_bypass,
  input  wire logic [3:0] dead_time_code,
  output logic            gate_drive
);

  gdsr_dt_state_t state_q;
  gdsr_dt_state_t state_d;
  logic [3:0]     cnt_q;
  logic [3:0]     cnt_d;
  logic           drive_q;
  logic           drive_d;

  // next state: hold the output low for the whole dead time
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    drive_d = 1'b0;
    if (!drive_enable || !turn_on_request) begin
      state_d = GDSR_DT_IDLE;
    end else begin
      unique case (state_q)
        GDSR_DT_IDLE: begin
          if (dead_time_bypass) begin
            state_d = GDSR_DT_ON;
            drive_d = 1'b1;
          end else begin
            // code latched here so a rewrite mid-delay cannot glitch it
            state_d = GDSR_DT_WAIT;
            cnt_d   = gdsr_dt_cycles(dead_time_code) - 4'h1;
          end
        end
        GDSR_DT_WAIT: begin
          if (cnt_q == 4'h0) begin
            state_d = GDSR_DT_ON;
            drive_d = 1'b1;
          end else begin
            cnt_d = cnt_q - 4'h1;
          end
        end
        GDSR_DT_ON: begin
          drive_d = 1'b1;
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= GDSR_DT_IDLE;
      cnt_q   <= 4'h0;
      drive_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      drive_q <= drive_d;
    end
  end

  assign gate_drive = drive_q;

endmodule

/* File: verification/gdsr_analog_model.sv */
`timescale 1ns/1ns

// ==========================================================================
// analog side: raises turn-on requests, watches drives and the ref pin
module gdsr_analog_model (
  input  wire logic       ref_clk,
  input  wire logic       primary_gate_drive,
  input  wire logic       secondary_gate_drive,
  input  wire logic [7:0] external_ref_code,
  input  wire logic       external_ref_pin_connect,
  output logic            primary_turn_on_request,
  output logic            secondary_turn_on_request,
  output logic      [7:0] external_ref_pin_level
);
  initial begin
    primary_turn_on_request   = 1'b0;
    secondary_turn_on_request = 1'b0;
  end

  // requests change only right after a rising edge
  task automatic request(input int pri, input logic lvl);
    @(posedge ref_clk);
    if (pri != 0) begin
      primary_turn_on_request <= lvl;
    end else begin
      secondary_turn_on_request <= lvl;
    end
  endtask

  // pin floats when not connected; show inverted code, not a stale copy
  assign external_ref_pin_level = external_ref_pin_connect ?
    external_ref_code : ~external_ref_code;
endmodule

/* File: verification/gdsr_regs_tb.sv */
`timescale 1ns/1ns

// ==========================================================================
// bench: register bus driver, read monitor, dead-time latency checks
module gdsr_regs_tb;
  import gdsr_pkg::*;
  logic       ref_clk = 1'b0;
  logic       resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic       rd_seen = 1'b0;
  logic [7:0] reg_rdata, dac_code, ext_code, pin_lvl;
  logic       p_req, s_req, p_drv, s_drv, pin_con;
  logic [7:0] exp_q[$];
  logic [7:0] v;
  int         fail_count = 0;
  int         n_tests = 0;
  int         cyc = 0;

  always #25 ref_clk = ~ref_clk;

  gdsr_regs gdsr_regs_inst (
    .ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .primary_turn_on_request(p_req),
    .secondary_turn_on_request(s_req), .primary_gate_drive(p_drv),
    .secondary_gate_drive(s_drv), .regulation_dac_code(dac_code),
    .external_ref_code(ext_code), .external_ref_pin_connect(pin_con));

  gdsr_analog_model gdsr_analog_model_inst (
    .ref_clk(ref_clk), .primary_gate_drive(p_drv),
    .secondary_gate_drive(s_drv), .external_ref_code(ext_code),
    .external_ref_pin_connect(pin_con), .primary_turn_on_request(p_req),
    .secondary_turn_on_request(s_req), .external_ref_pin_level(pin_lvl));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ========================================================================
  // one-cycle strobes; the next call waits an edge, so no double assignment
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge ref_clk);
    reg_read <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe; compare then
  always @(posedge ref_clk) begin
    if (rd_seen) begin
      check(reg_rdata, exp_q.pop_front());
    end
    rd_seen <= reg_read;
    cyc <= cyc + 1;
    if (cyc > 6000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // ========================================================================
  // turn-on latency: whole cycles covering 16 ns * (code + 1), min one
  task automatic meas(input int pri, input logic [3:0] c, input logic by);
    int n;
    int e;
    e = (16 * (int'(c) + 1) + 49) / 50;
    // bypass adds no delay: drive is up at the first edge seeing the request
    if (by) e = 0;
    wr(8'h00, pri != 0 ? {c, 4'h0} : {4'h0, c});
    wr(8'h03, pri != 0 ? {2'b10, by, 5'h00} : {3'b010, by, 4'h0});
    gdsr_analog_model_inst.request(pri, 1'b1);
    @(posedge ref_clk);
    n = 0;
    #1;
    while ((pri != 0 ? p_drv : s_drv) !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check(8'(n), 8'(e));
    check({6'h00, p_drv, s_drv}, pri != 0 ? 8'h02 : 8'h01);
    rd(8'h05, pri != 0 ? 8'h02 : 8'h01);
    gdsr_analog_model_inst.request(pri, 1'b0);
    repeat (2) @(posedge ref_clk);
    #1;
    check({6'h00, p_drv, s_drv}, 8'h00);
  endtask

  initial begin
    void'($urandom(39));
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    // reset values, status and two unmapped addresses
    for (int a = 0; a < 8; a++) begin
      rd(8'(a), 8'h00);
    end
    // set-point and reference codes reach the dac outputs
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(8'h01, v);
      #1;
      check(dac_code, v);
      rd(8'h01, v);
      v = 8'($urandom);
      wr(8'h02, v);
      #1;
      check(ext_code, v);
      rd(8'h02, v);
      wr(8'h00, v);
      rd(8'h00, v);
    end
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h00);
    wr(8'h07, 8'hFF);
    rd(8'h07, 8'h00);
    wr(8'h03, 8'hFF);
    rd(8'h03, 8'hF0);
    // every mode: pin is connected only in master mode
    for (int m = 0; m < 4; m++) begin
      wr(8'h04, 8'(m));
      #1;
      check({7'h00, pin_con}, m == 1 ? 8'h01 : 8'h00);
      check(pin_lvl, m == 1 ? ext_code : ~ext_code);
      rd(8'h04, 8'(m));
    end
    // every dead-time code on both drivers, then bypass
    for (int c = 0; c < 16; c++) begin
      meas(1, 4'(c), 1'b0);
      meas(0, 4'(c), 1'b0);
    end
    meas(1, 4'hF, 1'b1);
    meas(0, 4'hF, 1'b1);
    // enable off keeps one drive low while the other still turns on
    wr(8'h03, 8'h40);
    gdsr_analog_model_inst.request(1, 1'b1);
    gdsr_analog_model_inst.request(0, 1'b1);
    repeat (8) @(posedge ref_clk);
    #1;
    check({6'h00, p_drv, s_drv}, 8'h01);
    wr(8'h03, 8'h80);
    repeat (8) @(posedge ref_clk);
    #1;
    check({6'h00, p_drv, s_drv}, 8'h02);
    gdsr_analog_model_inst.request(1, 1'b0);
    gdsr_analog_model_inst.request(0, 1'b0);
    repeat (3) @(posedge ref_clk);
    check(8'(exp_q.size()), 8'h00);
    report_and_stop();
  end
endmodule
